// File: logic/ckrg_pkg.sv
// constants for the clock, align-reference and range configuration registers
package ckrg_pkg;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_FIRST = 8'h2a;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_SECOND = 8'h2b;
  localparam logic [7:0] ADDR_EDGE_POSITION = 8'h2c;
  localparam logic [7:0] ADDR_FULLSCALE_A = 8'h30;
  localparam logic [7:0] ADDR_FULLSCALE_B = 8'h32;
  localparam logic [7:0] RESET_CLOCK_CONTROL_FIRST = 8'h00;
  localparam logic [7:0] RESET_CLOCK_CONTROL_SECOND = 8'h11;
  localparam logic [15:0] RESET_FULLSCALE = 16'ha000;
  localparam logic [23:0] RESET_EDGE_POSITION = 24'h00_0000;
  localparam int BIT_POLARITY_INVERT = 0;
  localparam int BIT_REF_DC_PECL = 1;
  localparam int BIT_CLOCK_DC_PECL = 2;
  localparam int BIT_MARKER_ROUTE = 3;
  localparam int BIT_NOISE_SUPPRESS = 2;
  localparam int BIT_FEEDBACK_GAIN = 4;
  localparam int BIT_DELAY_LSB = 0;
  localparam int BIT_DELAY_MSB = 1;
endpackage

// File: logic/ckrg_sync.sv
// three-stage synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module ckrg_sync
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  logic stage2;
  logic stage3;
  wire agree = (stage2 == stage3);
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (agree)
      begin
        sync_out <= stage3;
      end
    end
  end
endmodule

// File: logic/ckrg_regs.sv
// configuration and status register bank for clocking and full-scale range
//
// Contract
// [R1] marker route plus enable puts reference on lsb
// [R2] marker route takes timestamp from align reference
// [R3] bit 2 selects dc pecl device clock
// [R4] bit 1 selects dc pecl align reference
// [R5] bit 0 inverts align reference polarity
// [R6] second clock word eight bits, reset 0x11
// [R7] bit 4 feedback gain, high, resets one
// [R8] host should set supply noise suppression
// [R9] bits 1:0 one-hot sample delay, reset 1
// [R10] 24-bit edge position status word reported
// [R11] edge position read-only, undefined until measured
// [R12] host uses position to pick delay select
// [R13] channel a range word, reset 0xa000
// [R14] host keeps range at or above 0x2000
// [R15] channel b range word at 0x32
// [R16] host leaves delay select zero for calibration
// [R17] channel b range same encoding as a
// [R18] reserved bits reset zero, read back written
`timescale 1ns/1ps
module ckrg_regs
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic align_ref_in,
  input wire logic timestamp_in,
  input wire logic sample_marker_enable,
  input wire logic position_valid,
  input wire logic [23:0] position_value,
  input wire logic [7:0] sample_in,
  output logic [7:0] sample_out,
  output logic align_ref_aligned,
  output logic device_clock_dc_pecl_mode,
  output logic align_ref_dc_pecl_mode,
  output logic clock_converter_feedback_gain,
  output logic analog_supply_noise_suppress,
  output logic [1:0] sample_clock_delay_select,
  output logic [15:0] fullscale_adjust_chan_a,
  output logic [15:0] fullscale_adjust_chan_b
);
  logic [7:0] clock_control_first;
  logic [7:0] clock_control_second;
  logic [23:0] align_ref_edge_position;
  logic [15:0] fullscale_range_chan_a;
  logic [15:0] fullscale_range_chan_b;
  logic ref_sync;
  logic stamp_sync;
  logic [7:0] next_rdata;

  // pins are asynchronous to the control clock, so both pass a synchroniser
  ckrg_sync u_ref_sync
  (
    .clock(clock),
    .nrst(nrst),
    .async_in(align_ref_in),
    .sync_out(ref_sync)
  );
  ckrg_sync u_stamp_sync
  (
    .clock(clock),
    .nrst(nrst),
    .async_in(timestamp_in),
    .sync_out(stamp_sync)
  );

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
    hit = (addr == base);
  endfunction

  wire wr_first = reg_write && hit(reg_addr, ckrg_pkg::ADDR_CLOCK_CONTROL_FIRST);
  wire wr_second = reg_write && hit(reg_addr, ckrg_pkg::ADDR_CLOCK_CONTROL_SECOND);
  wire wr_a_lo = reg_write && hit(reg_addr, ckrg_pkg::ADDR_FULLSCALE_A);
  wire wr_a_hi = reg_write && hit(reg_addr, ckrg_pkg::ADDR_FULLSCALE_A + 8'h01);
  wire wr_b_lo = reg_write && hit(reg_addr, ckrg_pkg::ADDR_FULLSCALE_B);
  wire wr_b_hi = reg_write && hit(reg_addr, ckrg_pkg::ADDR_FULLSCALE_B + 8'h01);
  // [R5] polarity inversion
  wire ref_aligned = ref_sync ^ clock_control_first[ckrg_pkg::BIT_POLARITY_INVERT];
  wire marker_route = clock_control_first[ckrg_pkg::BIT_MARKER_ROUTE];
  // [R2] timestamp source select
  wire marker_source = marker_route ? ref_aligned : stamp_sync;
  // [R1] marker on sample lsb
  // enable alone marks from the dedicated pin; the route bit only swaps the source
  wire marker_on = sample_marker_enable;
  wire [7:0] next_sample = marker_on ? {sample_in[7:1], marker_source} : sample_in;

  // [R11] read-only status, no write path; multi-byte words read little-endian
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      ckrg_pkg::ADDR_CLOCK_CONTROL_FIRST: next_rdata = clock_control_first;
      ckrg_pkg::ADDR_CLOCK_CONTROL_SECOND: next_rdata = clock_control_second;
      ckrg_pkg::ADDR_EDGE_POSITION: next_rdata = align_ref_edge_position[7:0];
      ckrg_pkg::ADDR_EDGE_POSITION + 8'h01: next_rdata = align_ref_edge_position[15:8];
      ckrg_pkg::ADDR_EDGE_POSITION + 8'h02: next_rdata = align_ref_edge_position[23:16];
      ckrg_pkg::ADDR_FULLSCALE_A: next_rdata = fullscale_range_chan_a[7:0];
      ckrg_pkg::ADDR_FULLSCALE_A + 8'h01: next_rdata = fullscale_range_chan_a[15:8];
      ckrg_pkg::ADDR_FULLSCALE_B: next_rdata = fullscale_range_chan_b[7:0];
      ckrg_pkg::ADDR_FULLSCALE_B + 8'h01: next_rdata = fullscale_range_chan_b[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // [R18] reserved bits stored as written
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_control_first <= ckrg_pkg::RESET_CLOCK_CONTROL_FIRST;
    end
    else if (wr_first)
    begin
      clock_control_first <= reg_wdata;
    end
  end

  // [R6] second clock word with its reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_control_second <= ckrg_pkg::RESET_CLOCK_CONTROL_SECOND;
    end
    else if (wr_second)
    begin
      clock_control_second <= reg_wdata;
    end
  end

  // [R13] channel a range word
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fullscale_range_chan_a <= ckrg_pkg::RESET_FULLSCALE;
    end
    else
    begin
      if (wr_a_lo)
      begin
        fullscale_range_chan_a[7:0] <= reg_wdata;
      end
      if (wr_a_hi)
      begin
        fullscale_range_chan_a[15:8] <= reg_wdata;
      end
    end
  end

  // [R15] channel b range word, [R17] same encoding
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fullscale_range_chan_b <= ckrg_pkg::RESET_FULLSCALE;
    end
    else
    begin
      if (wr_b_lo)
      begin
        fullscale_range_chan_b[7:0] <= reg_wdata;
      end
      if (wr_b_hi)
      begin
        fullscale_range_chan_b[15:8] <= reg_wdata;
      end
    end
  end

  // [R10] capture measured edge position
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      align_ref_edge_position <= ckrg_pkg::RESET_EDGE_POSITION;
    end
    else if (position_valid)
    begin
      align_ref_edge_position <= position_value;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
      sample_out <= 8'h00;
      align_ref_aligned <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
      sample_out <= next_sample;
      align_ref_aligned <= ref_aligned;
    end
  end

  // mode outputs registered again so every top output leaves a flip-flop
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      device_clock_dc_pecl_mode <= 1'b0;
      align_ref_dc_pecl_mode <= 1'b0;
      clock_converter_feedback_gain <=
        ckrg_pkg::RESET_CLOCK_CONTROL_SECOND[ckrg_pkg::BIT_FEEDBACK_GAIN];
      analog_supply_noise_suppress <= 1'b0;
      sample_clock_delay_select <=
        ckrg_pkg::RESET_CLOCK_CONTROL_SECOND[ckrg_pkg::BIT_DELAY_MSB:ckrg_pkg::BIT_DELAY_LSB];
      fullscale_adjust_chan_a <= ckrg_pkg::RESET_FULLSCALE;
      fullscale_adjust_chan_b <= ckrg_pkg::RESET_FULLSCALE;
    end
    else
    begin
      // [R3] device clock pecl mode
      device_clock_dc_pecl_mode <= clock_control_first[ckrg_pkg::BIT_CLOCK_DC_PECL];
      // [R4] reference pecl mode
      align_ref_dc_pecl_mode <= clock_control_first[ckrg_pkg::BIT_REF_DC_PECL];
      // [R7] feedback gain select
      clock_converter_feedback_gain <= clock_control_second[ckrg_pkg::BIT_FEEDBACK_GAIN];
      analog_supply_noise_suppress <= clock_control_second[ckrg_pkg::BIT_NOISE_SUPPRESS];
      // [R9] one-hot delay passed as written
      sample_clock_delay_select <=
        clock_control_second[ckrg_pkg::BIT_DELAY_MSB:ckrg_pkg::BIT_DELAY_LSB];
      fullscale_adjust_chan_a <= fullscale_range_chan_a;
      fullscale_adjust_chan_b <= fullscale_range_chan_b;
    end
  end

  a_gain_follows: assert property (@(posedge clock) disable iff (!nrst)
    wr_second ##1 1'b1 ##1 1'b1 |-> clock_converter_feedback_gain == $past(reg_wdata[4], 2))
    else $error("feedback gain not taken from write"); // [R7]
  a_delay_follows: assert property (@(posedge clock) disable iff (!nrst)
    wr_second |=> ##1 sample_clock_delay_select == $past(reg_wdata[1:0], 2))
    else $error("sample delay not taken from write"); // [R9]
  a_clock_pecl: assert property (@(posedge clock) disable iff (!nrst)
    wr_first |=> ##1 device_clock_dc_pecl_mode == $past(reg_wdata[2], 2))
    else $error("device clock pecl mode wrong"); // [R3]
  a_ref_pecl: assert property (@(posedge clock) disable iff (!nrst)
    wr_first |=> ##1 align_ref_dc_pecl_mode == $past(reg_wdata[1], 2))
    else $error("reference pecl mode wrong"); // [R4]
  a_invert_ref: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> align_ref_aligned == ($past(ref_sync) ^ $past(clock_control_first[0])))
    else $error("reference polarity wrong"); // [R5]
  a_marker_lsb: assert property (@(posedge clock) disable iff (!nrst)
    marker_route && sample_marker_enable |=> sample_out[0] ==
    ($past(ref_sync) ^ $past(clock_control_first[ckrg_pkg::BIT_POLARITY_INVERT])))
    else $error("marker missing on lsb"); // [R1]
  a_stamp_source: assert property (@(posedge clock) disable iff (!nrst)
    sample_marker_enable && !marker_route |=> sample_out[0] == $past(stamp_sync))
    else $error("timestamp not from dedicated pin"); // [R2]
  a_pos_capture: assert property (@(posedge clock) disable iff (!nrst)
    position_valid |=> align_ref_edge_position == $past(position_value))
    else $error("edge position not captured"); // [R10]
  a_pos_readonly: assert property (@(posedge clock) disable iff (!nrst)
    !position_valid |=> $stable(align_ref_edge_position))
    else $error("edge position changed without measurement"); // [R11]
  a_range_a_lo: assert property (@(posedge clock) disable iff (!nrst)
    wr_a_lo |=> ##1 fullscale_adjust_chan_a[7:0] == $past(reg_wdata, 2))
    else $error("channel a range low byte wrong"); // [R13]
  a_range_b_hi: assert property (@(posedge clock) disable iff (!nrst)
    wr_b_hi |=> ##1 fullscale_adjust_chan_b[15:8] == $past(reg_wdata, 2))
    else $error("channel b range high byte wrong"); // [R15]
  sequence s_first_write;
    wr_first;
  endsequence
  sequence s_first_read;
    reg_read && !reg_write && reg_addr == ckrg_pkg::ADDR_CLOCK_CONTROL_FIRST;
  endsequence
  a_reserved_readback: assert property (@(posedge clock) disable iff (!nrst)
    s_first_write ##1 s_first_read |=> reg_rdata == $past(reg_wdata, 2))
    else $error("first clock word readback wrong"); // [R18]
endmodule

// File: sim/ckrg_regs_test.sv
// self-checking bench for the clock, align-reference and range register bank
`timescale 1ns/1ps
module ckrg_regs_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic align_ref_in = 1'b0;
  logic timestamp_in = 1'b0;
  logic sample_marker_enable = 1'b0;
  logic position_valid = 1'b0;
  logic [23:0] position_value = 24'h00_0000;
  logic [7:0] sample_in = 8'h5a;
  logic [7:0] sample_out;
  logic align_ref_aligned, device_clock_dc_pecl_mode, align_ref_dc_pecl_mode;
  logic clock_converter_feedback_gain, analog_supply_noise_suppress;
  logic [1:0] sample_clock_delay_select;
  logic [15:0] fullscale_adjust_chan_a, fullscale_adjust_chan_b;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  ckrg_regs ckrg_regs_i
  (
    .clock(clock), .nrst(nrst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .align_ref_in(align_ref_in), .timestamp_in(timestamp_in),
    .sample_marker_enable(sample_marker_enable), .position_valid(position_valid),
    .position_value(position_value), .sample_in(sample_in), .sample_out(sample_out),
    .align_ref_aligned(align_ref_aligned),
    .device_clock_dc_pecl_mode(device_clock_dc_pecl_mode),
    .align_ref_dc_pecl_mode(align_ref_dc_pecl_mode),
    .clock_converter_feedback_gain(clock_converter_feedback_gain),
    .analog_supply_noise_suppress(analog_supply_noise_suppress),
    .sample_clock_delay_select(sample_clock_delay_select),
    .fullscale_adjust_chan_a(fullscale_adjust_chan_a),
    .fullscale_adjust_chan_b(fullscale_adjust_chan_b)
  );

  always #5 clock = ~clock;

  task automatic summarize();
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // whole run needs about a hundred cycles; a hang stops well past that
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one-cycle strobe, then an idle cycle so the next call never re-raises it in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    chk(24'(reg_rdata), 24'(e), "read data");
    @(negedge clock);
  endtask

  // write, then read the same byte in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk(24'(reg_rdata), 24'(d), "write readback");
    @(negedge clock);
  endtask

  task automatic t_reset();
    chk(24'(clock_converter_feedback_gain), 24'h00_0001, "gain reset");
    chk(24'(sample_clock_delay_select), 24'h00_0001, "delay reset");
    chk(24'(fullscale_adjust_chan_a), 24'h00_a000, "range a reset");
    chk(24'(fullscale_adjust_chan_b), 24'h00_a000, "range b reset");
    rd(8'h2b, 8'h11);
    rd(8'h2a, 8'h00);
    rd(8'h31, 8'ha0);
    rd(8'h32, 8'h00);
    rd(8'h33, 8'ha0);
  endtask

  task automatic t_ctrl2();
    wr(8'h2b, 8'h05);
    @(negedge clock);
    chk(24'(clock_converter_feedback_gain), 24'h00_0000, "gain low");
    chk(24'(analog_supply_noise_suppress), 24'h00_0001, "suppress");
    chk(24'(sample_clock_delay_select), 24'h00_0001, "delay 01");
    wr(8'h2b, 8'h12);
    @(negedge clock);
    chk(24'(sample_clock_delay_select), 24'h00_0002, "delay 10");
    chk(24'(clock_converter_feedback_gain), 24'h00_0001, "gain high");
    chk(24'(analog_supply_noise_suppress), 24'h00_0000, "suppress off");
    wr_rd(8'h2b, 8'he8);
    chk(24'(clock_converter_feedback_gain), 24'h00_0000, "reserved no effect");
  endtask

  task automatic t_ctrl1();
    wr_rd(8'h2a, 8'hf7);
    repeat (8) @(negedge clock);
    chk(24'(device_clock_dc_pecl_mode), 24'h00_0001, "clock pecl");
    chk(24'(align_ref_dc_pecl_mode), 24'h00_0001, "ref pecl");
    chk(24'(align_ref_aligned), 24'h00_0001, "inverted ref");
    rd(8'h2a, 8'hf7);
    wr_rd(8'h2a, 8'h00);
    repeat (8) @(negedge clock);
    chk(24'(align_ref_aligned), 24'h00_0000, "plain ref");
    chk(24'(device_clock_dc_pecl_mode), 24'h00_0000, "clock default");
    chk(24'(align_ref_dc_pecl_mode), 24'h00_0000, "ref default");
  endtask

  task automatic t_marker();
    sample_marker_enable = 1'b1;
    timestamp_in = 1'b1;
    repeat (8) @(negedge clock);
    chk(24'(sample_out), 24'h00_005b, "marker from timestamp pin");
    wr(8'h2a, 8'h08);
    repeat (8) @(negedge clock);
    chk(24'(sample_out), 24'h00_005a, "marker from ref low");
    align_ref_in = 1'b1;
    timestamp_in = 1'b0;
    repeat (8) @(negedge clock);
    chk(24'(sample_out), 24'h00_005b, "marker from ref high");
    sample_marker_enable = 1'b0;
    sample_in = 8'ha4;
    repeat (2) @(negedge clock);
    chk(24'(sample_out), 24'h00_00a4, "route alone no mark");
  endtask

  task automatic t_position();
    position_value = 24'h12_3456;
    position_valid = 1'b1;
    @(negedge clock);
    position_valid = 1'b0;
    position_value = 24'hff_ffff;
    wr(8'h2c, 8'h99);
    // host reads the captured position back, low byte first
    rd(8'h2c, 8'h56);
    rd(8'h2d, 8'h34);
    rd(8'h2e, 8'h12);
    rd(8'h40, 8'h00);
    wr(8'h29, 8'h00);
  endtask

  task automatic t_range();
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h20);
    wr(8'h32, 8'hff);
    wr(8'h33, 8'hff);
    @(negedge clock);
    chk(24'(fullscale_adjust_chan_a), 24'h00_2000, "range a min");
    chk(24'(fullscale_adjust_chan_b), 24'h00_ffff, "range b max");
    rd(8'h32, 8'hff);
    nrst = 1'b0;
    @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    chk(24'(fullscale_adjust_chan_a), 24'h00_a000, "range a second reset");
    rd(8'h2b, 8'h11);
  endtask

  initial
  begin
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    t_reset();
    t_ctrl2();
    t_ctrl1();
    t_marker();
    t_position();
    t_range();
    summarize();
  end
endmodule
